// *** hdl/dag_pkg.sv ***
package dag_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // data space layout
  localparam int          PTR_COUNT          = 3;
  localparam logic [11:0] PTR0_PLAIN_ADDR    = 12'h0FEF;
  localparam logic [11:0] PTR_STRIDE         = 12'h0008;
  localparam logic [11:0] INDIRECT_ONE_ADDR  = 12'h0FE7;
  localparam logic [11:0] SLOT_PLAIN         = 12'h0000;
  localparam logic [11:0] SLOT_POST_INC      = 12'h0001;
  localparam logic [11:0] SLOT_POST_DEC      = 12'h0002;
  localparam logic [11:0] SLOT_PRE_INC       = 12'h0003;
  localparam logic [11:0] SLOT_ACC_OFFSET    = 12'h0004;
  localparam logic [11:0] SLOT_HIGH_BYTE     = 12'h0005;
  localparam logic [11:0] SLOT_LOW_BYTE      = 12'h0006;
  localparam logic [11:0] PTR_STEP           = 12'h0001;
  localparam logic [7:0]  INDEXED_LIMIT      = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT       = 8'h80;
  localparam logic [3:0]  ACCESS_LOW_BANK    = 4'h0;
  localparam logic [3:0]  ACCESS_HIGH_BANK   = 4'hF;
  localparam logic [7:0]  VIRTUAL_READ_VALUE = 8'h00;
  localparam logic [7:0]  ACC_PLUS_TOP       = 8'h80;
  localparam int          INDEX_PTR          = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // apb register map, byte addresses
  localparam logic [11:0] REG_PTR0    = 12'h0000;
  localparam logic [11:0] REG_PTR1    = 12'h0004;
  localparam logic [11:0] REG_PTR2    = 12'h0008;
  localparam logic [11:0] REG_BANK    = 12'h000C;
  localparam logic [11:0] REG_ACCUM   = 12'h0010;
  localparam logic [11:0] REG_CONTROL = 12'h0014;
  localparam logic [11:0] REG_TARGET  = 12'h0018;
  localparam int          CTRL_EXT_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    MODE_PLAIN,
    MODE_POST_INC,
    MODE_POST_DEC,
    MODE_PRE_INC,
    MODE_ACC_OFFSET
  } dag_mode_t;

  typedef struct packed {
    logic       access_bit;
    logic [7:0] file_addr;
    logic       write;
    logic [7:0] wdata;
  } dag_op_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } dag_ram_t;

  typedef struct packed {
    logic      is_virtual;
    logic      is_low;
    logic      is_high;
    logic [1:0] idx;
    dag_mode_t mode;
  } dag_slot_t;

  typedef struct packed {
    logic [PTR_COUNT-1:0][11:0] ptr;
    logic [3:0]                 bank;
    logic [7:0]                 accum;
    logic                       ext_enable;
    logic [11:0]                last_target;
    dag_ram_t                   ram;
    logic                       rd_pend;
    logic                       rd_local;
    logic [7:0]                 rd_local_data;
    logic [7:0]                 op_rdata;
    logic                       op_rvalid;
    logic [31:0]                prdata;
    logic                       perr;
  } dag_state_t;

endpackage

// *** hdl/dag_core.sv ***
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - after-decrement operand addresses pointer, then pointer drops by one.
// - after-increment operand addresses pointer, then pointer rises by one.
// - before-increment operand raises pointer first, then addresses new value.
// - accumulator-offset operand addresses pointer plus accumulator taken as -127..128 (80h is +128); nothing changes.
// - plain indirect operand addresses pointer directly; pointer unchanged.
// - steps act on the whole 12-bit pair; carry and borrow cross bytes.
// - pointer steps never touch any arithmetic status flag.
// - indirect access onto a virtual operand reads 00h; writes do nothing.
// - writing a pair's own operand stores the value with no step.
// - extended mode, access bit 0, file address up to 5Fh: indexed offset.
// - indexed target is third pointer plus file address, anywhere in space.
// - access bit 0, address 60h up: low half bank 0, upper half F80h-FFFh.
// - access bit 1: bank select joined with file address, never remapped.
// - extended mode leaves pairs zero and one indirect addressing unchanged.
// - each pair holds 12 bits; upper four high-byte bits unimplemented.
// - direct access bit 1 builds full address from bank; 0 uses access bank.
// - indirect accesses ignore bank select and access bit.
module dag_core (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // decode stage operand request
  input  wire logic              op_valid,
  input  wire dag_pkg::dag_op_t  op,
  output logic      [7:0]        op_rdata,
  output logic                   op_rvalid,
  // data ram
  output dag_pkg::dag_ram_t      ram,
  input  wire logic [7:0]        ram_rdata
);

  ////////////////////////////////////////////////////////////////////////////////
  // address classification

  function automatic dag_pkg::dag_slot_t classify(input logic [11:0] a);
    dag_pkg::dag_slot_t r;
    logic [11:0]        base;
    logic [11:0]        d;
    r = '0;
    r.mode = dag_pkg::MODE_PLAIN;
    for (int i = 0; i < dag_pkg::PTR_COUNT; i++) begin
      base = dag_pkg::PTR0_PLAIN_ADDR - 12'(i * 8);
      d    = base - a;
      if (d == dag_pkg::SLOT_PLAIN || d == dag_pkg::SLOT_POST_INC ||
          d == dag_pkg::SLOT_POST_DEC || d == dag_pkg::SLOT_PRE_INC ||
          d == dag_pkg::SLOT_ACC_OFFSET) begin
        r.is_virtual = 1'b1;
        r.idx        = 2'(i);
        if (d == dag_pkg::SLOT_POST_INC) begin
          r.mode = dag_pkg::MODE_POST_INC;
        end else if (d == dag_pkg::SLOT_POST_DEC) begin
          r.mode = dag_pkg::MODE_POST_DEC;
        end else if (d == dag_pkg::SLOT_PRE_INC) begin
          r.mode = dag_pkg::MODE_PRE_INC;
        end else if (d == dag_pkg::SLOT_ACC_OFFSET) begin
          r.mode = dag_pkg::MODE_ACC_OFFSET;
        end
      end
      if (d == dag_pkg::SLOT_HIGH_BYTE) begin
        r.is_high = 1'b1;
        r.idx     = 2'(i);
      end
      if (d == dag_pkg::SLOT_LOW_BYTE) begin
        r.is_low = 1'b1;
        r.idx    = 2'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state

  dag_pkg::dag_state_t s;
  dag_pkg::dag_state_t next_s;

  dag_pkg::dag_slot_t  src_slot;
  dag_pkg::dag_slot_t  dst_slot;
  logic [11:0]         direct_addr;
  logic [11:0]         target;
  logic [11:0]         ptr_val;
  logic [11:0]         ptr_new;
  logic                ptr_step;
  logic                is_local;

  always_comb begin
    next_s      = s;
    src_slot    = '0;
    dst_slot    = '0;
    direct_addr = '0;
    target      = '0;
    ptr_val     = '0;
    ptr_new     = '0;
    ptr_step    = 1'b0;
    is_local    = 1'b0;

    next_s.op_rvalid = 1'b0;
    next_s.ram.valid = 1'b0;
    next_s.ram.write = 1'b0;
    next_s.rd_pend   = 1'b0;

    // read answer lands two edges after the request
    if (s.rd_pend) begin
      next_s.op_rdata  = s.rd_local ? s.rd_local_data : ram_rdata;
      next_s.op_rvalid = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // operand address resolution
    if (op_valid) begin
      if (op.access_bit) begin
        direct_addr = {s.bank, op.file_addr};
      end else if (s.ext_enable && op.file_addr <= dag_pkg::INDEXED_LIMIT) begin
        direct_addr = s.ptr[dag_pkg::INDEX_PTR] + {4'h0, op.file_addr};
      end else if (op.file_addr >= dag_pkg::ACCESS_SPLIT) begin
        direct_addr = {dag_pkg::ACCESS_HIGH_BANK, op.file_addr};
      end else begin
        direct_addr = {dag_pkg::ACCESS_LOW_BANK, op.file_addr};
      end

      src_slot = classify(direct_addr);
      target   = direct_addr;

      // indirect path: bank and access bit play no part past here
      if (src_slot.is_virtual) begin
        ptr_val = s.ptr[src_slot.idx];
        unique case (src_slot.mode)
          dag_pkg::MODE_PLAIN: begin
            target = ptr_val;
          end
          dag_pkg::MODE_POST_INC: begin
            target   = ptr_val;
            ptr_new  = ptr_val + dag_pkg::PTR_STEP;
            ptr_step = 1'b1;
          end
          dag_pkg::MODE_POST_DEC: begin
            target   = ptr_val;
            ptr_new  = ptr_val - dag_pkg::PTR_STEP;
            ptr_step = 1'b1;
          end
          dag_pkg::MODE_PRE_INC: begin
            ptr_new  = ptr_val + dag_pkg::PTR_STEP;
            target   = ptr_new;
            ptr_step = 1'b1;
          end
          dag_pkg::MODE_ACC_OFFSET: begin
            // 80h stands for +128: reach is -127..128, not plain two's complement
            if (s.accum == dag_pkg::ACC_PLUS_TOP) begin
              target = ptr_val + {4'h0, s.accum};
            end else begin
              target = ptr_val + {{4{s.accum[7]}}, s.accum};
            end
          end
        endcase
      end

      dst_slot = classify(target);

      if (src_slot.is_virtual && dst_slot.is_virtual) begin
        // virtual onto virtual: nothing is reached
        is_local             = 1'b1;
        next_s.rd_local_data = dag_pkg::VIRTUAL_READ_VALUE;
      end else if (dst_slot.is_low || dst_slot.is_high) begin
        is_local             = 1'b1;
        next_s.rd_local_data = dst_slot.is_high ?
                               {4'h0, s.ptr[dst_slot.idx][11:8]} :
                               s.ptr[dst_slot.idx][7:0];
        // a write into the pair being walked beats its own step
        if (op.write && src_slot.is_virtual && dst_slot.idx == src_slot.idx) begin
          ptr_step = 1'b0;
        end
      end

      // step carries no status flags; there are none in this block
      if (ptr_step) begin
        next_s.ptr[src_slot.idx] = ptr_new;
      end

      if (is_local) begin
        if (op.write && (dst_slot.is_low || dst_slot.is_high) &&
            !(src_slot.is_virtual && dst_slot.is_virtual)) begin
          if (dst_slot.is_high) begin
            next_s.ptr[dst_slot.idx][11:8] = op.wdata[3:0];
          end else begin
            next_s.ptr[dst_slot.idx][7:0] = op.wdata;
          end
        end
      end else begin
        next_s.ram.valid = 1'b1;
        next_s.ram.write = op.write;
        next_s.ram.addr  = target;
        next_s.ram.wdata = op.wdata;
      end

      next_s.rd_pend     = !op.write;
      next_s.rd_local    = is_local;
      next_s.last_target = target;
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb: decode in setup, answer in first access cycle
    if (psel && !penable) begin
      next_s.perr   = 1'b0;
      next_s.prdata = '0;
      unique case (paddr)
        dag_pkg::REG_PTR0:    next_s.prdata = {20'h0_0000, s.ptr[0]};
        dag_pkg::REG_PTR1:    next_s.prdata = {20'h0_0000, s.ptr[1]};
        dag_pkg::REG_PTR2:    next_s.prdata = {20'h0_0000, s.ptr[2]};
        dag_pkg::REG_BANK:    next_s.prdata = {28'h000_0000, s.bank};
        dag_pkg::REG_ACCUM:   next_s.prdata = {24'h00_0000, s.accum};
        dag_pkg::REG_CONTROL: next_s.prdata = {31'h0000_0000, s.ext_enable};
        dag_pkg::REG_TARGET:  next_s.prdata = {20'h0_0000, s.last_target};
        default:              next_s.perr   = 1'b1;
      endcase
    end

    // software write lands last, so it wins over a same-cycle step
    if (psel && penable && pwrite && !s.perr) begin
      unique case (paddr)
        dag_pkg::REG_PTR0:    next_s.ptr[0]     = pwdata[11:0];
        dag_pkg::REG_PTR1:    next_s.ptr[1]     = pwdata[11:0];
        dag_pkg::REG_PTR2:    next_s.ptr[2]     = pwdata[11:0];
        dag_pkg::REG_BANK:    next_s.bank       = pwdata[3:0];
        dag_pkg::REG_ACCUM:   next_s.accum      = pwdata[7:0];
        dag_pkg::REG_CONTROL: next_s.ext_enable = pwdata[dag_pkg::CTRL_EXT_BIT];
        default:              next_s.bank       = s.bank;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata    = s.prdata;
  assign pready    = psel & penable;
  assign pslverr   = psel & penable & s.perr;
  assign op_rdata  = s.op_rdata;
  assign op_rvalid = s.op_rvalid;
  assign ram       = s.ram;

endmodule

// *** testbench/dag_ram_model.sv ***
`timescale 1ns/1ps
module dag_ram_model (
  // core side
  input  wire logic              pclk,
  input  wire dag_pkg::dag_ram_t ram,
  output logic      [7:0]        ram_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] noise = 8'h00;
  initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5A;
  // idle data keeps moving so a stale byte never passes
  always @(posedge pclk) begin
    noise <= noise + 8'h35;
    if (ram.valid && ram.write) mem[ram.addr] <= ram.wdata;
  end
  assign ram_rdata = (ram.valid && !ram.write) ? mem[ram.addr] : noise;
endmodule

// *** testbench/dag_core_sva.sv ***
`timescale 1ns/1ps
module dag_core_sva (
  // clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // operand and ram sides
  input wire logic              op_valid,
  input wire dag_pkg::dag_op_t  op,
  input wire logic [7:0]        op_rdata,
  input wire logic              op_rvalid,
  input wire dag_pkg::dag_ram_t ram,
  input wire logic [7:0]        ram_rdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ram_from_op: assert property (ram.valid |-> $past(op_valid))
    else $error("ram request without operand");
  a_rvalid_late: assert property (op_rvalid |-> $past(op_valid, 2) && !$past(op.write, 2))
    else $error("read answer not two cycles after read");
  a_rdata_ram: assert property (op_rvalid && $past(ram.valid && !ram.write) |->
    op_rdata == $past(ram_rdata)) else $error("read answer differs from ram");
  a_rdata_stands: assert property (!op_rvalid |-> $stable(op_rdata))
    else $error("read data moved without answer");
  a_wdata_pass: assert property (ram.valid && ram.write |-> ram.wdata == $past(op.wdata))
    else $error("ram write data wrong");
  a_bank_direct: assert property (op_valid && op.access_bit && op.file_addr < 8'hD9 |=>
    ram.valid && ram.addr[7:0] == $past(op.file_addr)) else $error("banked address wrong");
  a_forced_low: assert property (op_valid && !op.access_bit && op.file_addr inside
    {[8'h60:8'h7F]} |=> ram.valid && ram.addr == {4'h0, $past(op.file_addr)})
    else $error("low access bank address wrong");
  a_forced_high: assert property (op_valid && !op.access_bit && op.file_addr inside
    {[8'h80:8'hD8]} |=> ram.valid && ram.addr == {4'hF, $past(op.file_addr)}
    && ram.write == $past(op.write)) else $error("high access bank address wrong");
  c_indexed: cover property (op_valid && !op.access_bit && op.file_addr <= 8'h5F);
  c_zero_read: cover property (op_rvalid && op_rdata == 8'h00);
  c_ram_write: cover property (ram.valid && ram.write);
endmodule
bind dag_core dag_core_sva u_sva (.pclk, .presetn, .op_valid, .op, .op_rdata, .op_rvalid,
  .ram, .ram_rdata);

// *** testbench/data_address_generator_tb.sv ***
`timescale 1ns/1ps
module data_address_generator_tb;
  logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic              pwrite = 1'b0, pready, pslverr, op_valid = 1'b0, op_rvalid, e, ext;
  logic [11:0]       paddr = '0;
  logic [31:0]       pwdata = '0, prdata, r;
  logic [7:0]        op_rdata, ram_rdata, acc, f;
  logic [3:0]        bank;
  logic [7:0]        m [4096];
  dag_pkg::dag_op_t  op = '0;
  dag_pkg::dag_ram_t ram;
  int                fail_count = 0, samples_checked = 0, seed = 86;
  int                p [3];

  dag_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .op_valid, .op, .op_rdata, .op_rvalid, .ram, .ram_rdata);
  dag_ram_model far (.pclk, .ram, .ram_rdata);
  initial forever #10 pclk = ~pclk;
  initial begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int slot(int x);
    if (x < 12'h0FD9 || x > 12'h0FEF || (12'h0FEF - x) % 8 > 6) return -1;
    return 12'h0FEF - x;
  endfunction
  // reference model: virtual operands, pointer bytes, then plain ram
  task automatic predict(input logic a, w, input logic [7:0] wd, output logic ev,
                         output int t, output logic [7:0] er);
    int s, own, old;
    own = -1;
    old = 0;
    ev = 1'b0;
    er = 8'h00;
    if (a) t = {bank, f};
    else if (ext && f <= 8'h5F) t = (p[2] + f) & 12'h0FFF;
    else t = (f < 8'h80) ? f : 12'h0F00 + f;
    s = slot(t);
    if (s >= 0 && s % 8 < 5) begin
      own = s / 8;
      old = p[own];
      // offset reach is -127..128: 80h counts as +128
      t = (s % 8 == 3) ? old + 1 :
          (s % 8 == 4) ? old + ((acc == 8'h80) ? 128 : int'($signed(acc))) : old;
      t = t & 12'h0FFF;
      if (s % 8 == 1 || s % 8 == 3) p[own] = (old + 1) & 12'h0FFF;
      if (s % 8 == 2) p[own] = (old - 1) & 12'h0FFF;
      s = slot(t);
      if (s >= 0 && s % 8 < 5) return;
    end
    if (s >= 0) begin
      if (w && s / 8 == own) p[own] = old;
      if (w && s % 8 == 5) p[s / 8] = (p[s / 8] & 12'h00FF) | (int'(wd[3:0]) << 8);
      if (w && s % 8 == 6) p[s / 8] = (p[s / 8] & 12'h0F00) | wd;
      er = (s % 8 == 5) ? 8'(p[s / 8] >> 8) : 8'(p[s / 8]);
      return;
    end
    ev = 1'b1;
    if (w) m[t] = wd;
    er = m[t];
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a <= dag_pkg::REG_PTR2) p[a / 4] = d & 12'h0FFF;
    if (a == dag_pkg::REG_BANK) bank = d[3:0];
    if (a == dag_pkg::REG_ACCUM) acc = d[7:0];
    if (a == dag_pkg::REG_CONTROL) ext = d[0];
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask
  task automatic op_do(input logic a, input logic [7:0] fa, input logic w, input logic [7:0] wd);
    logic ev;
    int t;
    logic [7:0] er;
    f = fa;
    @(posedge pclk);
    op_valid <= 1'b1;
    op <= '{a, fa, w, wd};
    @(posedge pclk);
    op_valid <= 1'b0;
    predict(a, w, wd, ev, t, er);
    @(negedge pclk);
    chk(ram.valid, ev);
    if (ev) chk({ram.write, ram.addr, ram.wdata & {8{w}}}, {w, 12'(t), wd & {8{w}}});
    @(negedge pclk);
    chk(op_rvalid, !w);
    if (!w) chk(op_rdata, er);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 4096; i++) m[i] = 8'(i) ^ 8'h5A;
    p = '{0, 0, 0};
    {bank, acc, ext} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(dag_pkg::REG_PTR0, 32'h0000_0000);
    wr(dag_pkg::REG_PTR0, 32'hFFFF_FFFF);
    rd_chk(dag_pkg::REG_PTR0, 32'h0000_0FFF);
    apb(1'b0, 12'h001C, 32'h0000_0000);
    chk({e, r}, {1'b1, 32'h0000_0000});
    wr(dag_pkg::REG_PTR0, 32'h0000_00FF);
    op_do(1'b0, 8'hEE, 1'b0, 8'h00);
    op_do(1'b0, 8'hEF, 1'b0, 8'h00);
    op_do(1'b0, 8'hED, 1'b1, 8'hA5);
    op_do(1'b0, 8'hEF, 1'b0, 8'h00);
    op_do(1'b0, 8'hEC, 1'b0, 8'h00);
    rd_chk(dag_pkg::REG_PTR0, 32'h0000_0100);
    wr(dag_pkg::REG_ACCUM, 32'h0000_0080);
    wr(dag_pkg::REG_PTR0, 32'h0000_0010);
    op_do(1'b0, 8'hEB, 1'b0, 8'h00);
    rd_chk(dag_pkg::REG_PTR0, 32'h0000_0010);
    wr(dag_pkg::REG_PTR0, 32'h0000_0FE7);
    op_do(1'b0, 8'hEF, 1'b0, 8'h00);
    op_do(1'b0, 8'hEF, 1'b1, 8'h77);
    wr(dag_pkg::REG_PTR2, 32'h0000_0FD9);
    op_do(1'b0, 8'hDD, 1'b1, 8'h34);
    rd_chk(dag_pkg::REG_PTR2, 32'h0000_0F34);
    wr(dag_pkg::REG_CONTROL, 32'h0000_0001);
    wr(dag_pkg::REG_PTR2, 32'h0000_0FF0);
    wr(dag_pkg::REG_PTR1, 32'h0000_0123);
    wr(dag_pkg::REG_BANK, 32'h0000_0005);
    op_do(1'b0, 8'h5F, 1'b1, 8'h3C);
    op_do(1'b0, 8'h60, 1'b0, 8'h00);
    op_do(1'b0, 8'hE7, 1'b0, 8'h00);
    op_do(1'b1, 8'h10, 1'b0, 8'h00);
    wr(dag_pkg::REG_BANK, 32'h0000_000F);
    op_do(1'b1, 8'hE7, 1'b0, 8'h00);
    rd_chk(dag_pkg::REG_TARGET, 32'h0000_0123);
    op_do(1'b0, 8'hEA, 1'b1, 8'hF3);
    op_do(1'b0, 8'hEA, 1'b0, 8'h00);
    op_do(1'b0, 8'hE9, 1'b0, 8'h00);
    for (int i = 0; i < 64; i++) begin
      if (i % 8 == 0) begin
        for (int j = 0; j < 3; j++) wr(12'(4 * j), $random(seed) & 32'h0000_0EFF);
        wr(dag_pkg::REG_ACCUM, $random(seed));
        wr(dag_pkg::REG_BANK, {$random(seed)} % 15);
        wr(dag_pkg::REG_CONTROL, $random(seed) & 1);
      end
      r = $random(seed);
      f = r[23:16];
      if (f > 8'hD8) f = f - 8'h40;
      if (r[2]) f = 8'hEF - 8'(8 * (r[4:3] % 3)) - 8'(r[7:5] % 5);
      op_do(r[0], f, r[1], r[15:8]);
    end
    results();
  end
endmodule
